// file: rtl/ccc_pkg.sv
// Purpose: constants for the current converter control block
// Assumes: 32-bit apb, byte addresses equal the printed offsets
// Notes: times in ms, cycle counts come from the ms tick divider
package ccc_pkg;
   // register byte offsets
   localparam logic [11:0] OFS_CONTROL = 12'h000;
   localparam logic [11:0] OFS_RESULT = 12'h004;
   localparam logic [11:0] OFS_STATUS = 12'h008;
   localparam logic [11:0] OFS_SETUP = 12'h00c;
   localparam logic [11:0] OFS_CUSTOM = 12'h010;
   localparam logic [11:0] OFS_MSDIV = 12'h014;
   localparam logic [11:0] OFS_GAIN = 12'h018;
   localparam logic [11:0] OFS_INSEL = 12'h01c;
   localparam logic [11:0] OFS_LOTH = 12'h020;
   localparam logic [11:0] OFS_HITH = 12'h024;
   localparam logic [11:0] OFS_MASK = 12'h028;
   localparam logic [11:0] OFS_RAW = 12'h02c;
   localparam logic [11:0] OFS_MASKED = 12'h030;
   localparam logic [11:0] OFS_CLEAR = 12'h034;
   // control fields
   localparam int CTL_START = 0;
   localparam int CTL_STOP = 1;
   localparam int CTL_MODE = 2;
   // result and status fields
   localparam int RES_OVER = 16;
   localparam int STA_OVER = 0;
   localparam int STA_UNDER = 1;
   // setup fields
   localparam int SET_GAIN_LOW = 6;
   localparam int SET_OFS_ON = 8;
   localparam int SET_OFS_A = 9;
   localparam int SET_OFS_B = 10;
   localparam logic [10:0] SETUP_MASK = 11'h747;
   localparam logic [10:0] SETUP_RESET = 11'h043;
   // irq flag positions
   localparam int IRQ_DONE = 0;
   localparam int IRQ_LOW = 1;
   localparam int IRQ_HIGH = 2;
   // reset values
   localparam logic [13:0] MSDIV_RESET = 14'h0009;
   localparam logic [15:0] HITH_RESET = 16'hffff;
   localparam logic [3:0] GAIN_RESET = 4'h0;
   // integration time codes and their windows in ms
   localparam logic [2:0] INT_16MS = 3'h1;
   localparam logic [2:0] INT_20MS = 3'h2;
   localparam logic [2:0] INT_100MS = 3'h3;
   localparam logic [2:0] INT_200MS = 3'h4;
   localparam logic [2:0] INT_400MS = 3'h5;
   localparam logic [2:0] INT_CUSTOM = 3'h7;
   localparam logic [15:0] T16_MS = 16'd16;
   localparam logic [15:0] T20_MS = 16'd20;
   localparam logic [15:0] T100_MS = 16'd100;
   localparam logic [15:0] T200_MS = 16'd200;
   localparam logic [15:0] T400_MS = 16'd400;
   localparam logic [15:0] TMIN_MS = 16'd1;
   localparam logic [13:0] DIV_MIN = 14'h0001;
   typedef enum logic {CCC_IDLE, CCC_INTEG} ccc_state_e;
endpackage

// file: rtl/ccc_converter.sv
// Purpose: apb register file and sequencer of a current-to-frequency converter
// Assumes: analog front end gives a pulse train and range levels, async
// Notes: zero wait apb; reserved window codes run as 16 ms
//
// Behaviour
// - start bit clears itself when the running measurement ends
// - continuous mode stop lets the current conversion finish, then halts
// - stop write is ignored in single-shot mode
// - control bit 2 picks single-shot (0) or continuous (1)
// - reading the result register clears all pending irq flags
// - result bits 15:0 hold the last count, read only
// - result bit 16 reads one when the last conversion overflowed
// - status bit 0 reports overflow, result inaccurate
// - status bit 1 reports underflow, result inaccurate
// - window codes 1..5 give 16,20,100,200,400 ms; 7 custom
// - setup bit 6 picks gain, one is low gain, resets to one
// - setup bit 8 enables offset current, bits 9 and 10 pick sources
// - custom period register holds a 16-bit window in ms
// - 14-bit divider gives clocks per ms, resets to nine
// - registers decode at offsets 0x000 to 0x034
// - result below low threshold raises the low flag
// - result above high threshold raises the high flag
// - raw done flag sets on every finished conversion
// - masked flags are raw flags and mask, bits 0 to 2
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ccc_converter (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic afe_freq_pulse,
   input wire logic afe_over_range,
   input wire logic afe_under_range,
   output logic afe_integrate,
   output logic afe_gain_low,
   output logic afe_offset_on,
   output logic afe_offset_pick_a,
   output logic afe_offset_pick_b,
   output logic [5:0] afe_input_select,
   output logic [3:0] afe_input_gain,
   output logic irq
);
   ccc_pkg::ccc_state_e state_reg;
   logic start_reg, mode_reg, stop_pend_reg;
   logic [15:0] result_reg;
   logic over_flag_reg, under_flag_reg;
   logic [10:0] setup_reg;
   logic [15:0] custom_reg;
   logic [13:0] msdiv_reg;
   logic [3:0] gain_reg;
   logic [5:0] insel_reg;
   logic [15:0] loth_reg, hith_reg;
   logic [2:0] mask_reg, raw_reg;
   logic [31:0] prdata_reg;
   logic [13:0] div_cnt_reg;
   logic [15:0] ms_cnt_reg;
   logic [16:0] pulse_cnt_reg;
   logic [2:0] pulse_sync_reg;
   logic [1:0] over_sync_reg, under_sync_reg;
   logic setup_ph, wr_acc, rd_acc, mapped;
   logic ms_tick, win_end, conv_done, begin_conv;
   logic [15:0] win_ms, data_next;
   logic [13:0] div_limit;
   logic over_next;
   logic [2:0] raw_set, raw_clr;
   // control register write decode, used only by the mode register
   logic ctl_wr;

   // apb decode
   assign setup_ph = psel & ~penable;
   assign wr_acc = psel & penable & pwrite & mapped;
   assign rd_acc = psel & penable & ~pwrite & mapped;
   assign ctl_wr = wr_acc && (paddr == ccc_pkg::OFS_CONTROL);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = prdata_reg;

   always_comb begin
      if (paddr[1:0] != 2'b00) begin
         mapped = 1'b0;
      end else if (paddr > ccc_pkg::OFS_CLEAR) begin
         mapped = 1'b0;
      end else begin
         mapped = 1'b1;
      end
   end

   // read data captured in setup so it comes from a flop in access
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         prdata_reg <= 32'h0000_0000;
      end else if (setup_ph && !pwrite) begin
         prdata_reg <= 32'h0000_0000;
         if (paddr == ccc_pkg::OFS_CONTROL) begin
            prdata_reg[ccc_pkg::CTL_START] <= start_reg;
            prdata_reg[ccc_pkg::CTL_MODE] <= mode_reg;
         end else if (paddr == ccc_pkg::OFS_RESULT) begin
            prdata_reg[15:0] <= result_reg;
            prdata_reg[ccc_pkg::RES_OVER] <= over_flag_reg;
         end else if (paddr == ccc_pkg::OFS_STATUS) begin
            prdata_reg[ccc_pkg::STA_OVER] <= over_flag_reg;
            prdata_reg[ccc_pkg::STA_UNDER] <= under_flag_reg;
         end else if (paddr == ccc_pkg::OFS_SETUP) begin
            prdata_reg[10:0] <= setup_reg;
         end else if (paddr == ccc_pkg::OFS_CUSTOM) begin
            prdata_reg[15:0] <= custom_reg;
         end else if (paddr == ccc_pkg::OFS_MSDIV) begin
            prdata_reg[13:0] <= msdiv_reg;
         end else if (paddr == ccc_pkg::OFS_GAIN) begin
            prdata_reg[3:0] <= gain_reg;
         end else if (paddr == ccc_pkg::OFS_INSEL) begin
            prdata_reg[5:0] <= insel_reg;
         end else if (paddr == ccc_pkg::OFS_LOTH) begin
            prdata_reg[15:0] <= loth_reg;
         end else if (paddr == ccc_pkg::OFS_HITH) begin
            prdata_reg[15:0] <= hith_reg;
         end else if (paddr == ccc_pkg::OFS_MASK) begin
            prdata_reg[2:0] <= mask_reg;
         end else if (paddr == ccc_pkg::OFS_RAW) begin
            prdata_reg[2:0] <= raw_reg;
         end else if (paddr == ccc_pkg::OFS_MASKED) begin
            prdata_reg[2:0] <= raw_reg & mask_reg;
         end
      end
   end

   // mode is read at each window end, so it may change mid-run
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mode_reg <= 1'b0;
      end else if (ctl_wr) begin
         mode_reg <= pwdata[ccc_pkg::CTL_MODE];
      end
   end

   // window setup acts at once: change it only while idle
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         setup_reg <= ccc_pkg::SETUP_RESET;
         custom_reg <= 16'h0000;
         msdiv_reg <= ccc_pkg::MSDIV_RESET;
      end else if (wr_acc) begin
         if (paddr == ccc_pkg::OFS_SETUP) begin
            setup_reg <= pwdata[10:0] & ccc_pkg::SETUP_MASK;
         end else if (paddr == ccc_pkg::OFS_CUSTOM) begin
            custom_reg <= pwdata[15:0];
         end else if (paddr == ccc_pkg::OFS_MSDIV) begin
            msdiv_reg <= pwdata[13:0];
         end
      end
   end

   // input routing for the analog side
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         gain_reg <= ccc_pkg::GAIN_RESET;
         insel_reg <= 6'h00;
      end else if (wr_acc) begin
         if (paddr == ccc_pkg::OFS_GAIN) begin
            gain_reg <= pwdata[3:0];
         end else if (paddr == ccc_pkg::OFS_INSEL) begin
            insel_reg <= pwdata[5:0];
         end
      end
   end

   // thresholds compare against the saturated count
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         loth_reg <= 16'h0000;
         hith_reg <= ccc_pkg::HITH_RESET;
         mask_reg <= 3'h0;
      end else if (wr_acc) begin
         if (paddr == ccc_pkg::OFS_LOTH) begin
            loth_reg <= pwdata[15:0];
         end else if (paddr == ccc_pkg::OFS_HITH) begin
            hith_reg <= pwdata[15:0];
         end else if (paddr == ccc_pkg::OFS_MASK) begin
            mask_reg <= pwdata[2:0];
         end
      end
   end

   // front end inputs are asynchronous
   // reset low matches the idle pulse line: no false edge after reset
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pulse_sync_reg <= 3'h0;
      end else begin
         pulse_sync_reg <= {pulse_sync_reg[1:0], afe_freq_pulse};
      end
   end

   // range levels only matter at the window end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         over_sync_reg <= 2'h0;
         under_sync_reg <= 2'h0;
      end else begin
         over_sync_reg <= {over_sync_reg[0], afe_over_range};
         under_sync_reg <= {under_sync_reg[0], afe_under_range};
      end
   end

   // window length in ms
   always_comb begin
      case (setup_reg[2:0])
         ccc_pkg::INT_16MS: win_ms = ccc_pkg::T16_MS;
         ccc_pkg::INT_20MS: win_ms = ccc_pkg::T20_MS;
         ccc_pkg::INT_100MS: win_ms = ccc_pkg::T100_MS;
         ccc_pkg::INT_200MS: win_ms = ccc_pkg::T200_MS;
         ccc_pkg::INT_400MS: win_ms = ccc_pkg::T400_MS;
         ccc_pkg::INT_CUSTOM: begin
            // zero would never end; one ms is the floor
            if (custom_reg == 16'h0000) begin
               win_ms = ccc_pkg::TMIN_MS;
            end else begin
               win_ms = custom_reg;
            end
         end
         default: win_ms = ccc_pkg::T16_MS;
      endcase
   end

   // a zero divider would stall the tick, so it acts as one
   assign div_limit = (msdiv_reg == 14'h0000) ? ccc_pkg::DIV_MIN : msdiv_reg;
   assign ms_tick = (state_reg == ccc_pkg::CCC_INTEG) &&
                    (div_cnt_reg == div_limit - ccc_pkg::DIV_MIN);
   assign win_end = ms_tick && (ms_cnt_reg == win_ms - ccc_pkg::TMIN_MS);
   assign conv_done = win_end;
   assign begin_conv = wr_acc && (paddr == ccc_pkg::OFS_CONTROL) &&
                       pwdata[ccc_pkg::CTL_START] &&
                       (state_reg == ccc_pkg::CCC_IDLE);

   // tick and window counters
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt_reg <= 14'h0000;
         ms_cnt_reg <= 16'h0000;
      end else if (state_reg != ccc_pkg::CCC_INTEG || win_end) begin
         div_cnt_reg <= 14'h0000;
         ms_cnt_reg <= 16'h0000;
      end else if (ms_tick) begin
         div_cnt_reg <= 14'h0000;
         ms_cnt_reg <= ms_cnt_reg + ccc_pkg::TMIN_MS;
      end else begin
         div_cnt_reg <= div_cnt_reg + ccc_pkg::DIV_MIN;
      end
   end

   // pulse counter saturates one past the 16-bit range
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pulse_cnt_reg <= 17'h00000;
      end else if (state_reg != ccc_pkg::CCC_INTEG || win_end) begin
         pulse_cnt_reg <= 17'h00000;
      end else if (pulse_sync_reg[1] && !pulse_sync_reg[2] &&
                   !pulse_cnt_reg[16]) begin
         pulse_cnt_reg <= pulse_cnt_reg + 17'h00001;
      end
   end

   assign over_next = pulse_cnt_reg[16] | over_sync_reg[1];
   assign data_next = pulse_cnt_reg[16] ? 16'hffff : pulse_cnt_reg[15:0];

   // sequencer
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= ccc_pkg::CCC_IDLE;
         start_reg <= 1'b0;
         stop_pend_reg <= 1'b0;
      end else begin
         case (state_reg)
            ccc_pkg::CCC_IDLE: begin
               stop_pend_reg <= 1'b0;
               if (begin_conv) begin
                  state_reg <= ccc_pkg::CCC_INTEG;
                  start_reg <= 1'b1;
               end
            end
            default: begin
               if (wr_acc && paddr == ccc_pkg::OFS_CONTROL &&
                   pwdata[ccc_pkg::CTL_STOP] && mode_reg) begin
                  stop_pend_reg <= 1'b1;
               end
               if (conv_done) begin
                  // stop seen in the last cycle still ends the run
                  if (!mode_reg || stop_pend_reg ||
                      (wr_acc && paddr == ccc_pkg::OFS_CONTROL &&
                       pwdata[ccc_pkg::CTL_STOP])) begin
                     state_reg <= ccc_pkg::CCC_IDLE;
                     start_reg <= 1'b0;
                     stop_pend_reg <= 1'b0;
                  end
                  // otherwise stay integrating: next window starts now
               end
            end
         endcase
      end
   end

   // result and range flags
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         result_reg <= 16'h0000;
         over_flag_reg <= 1'b0;
         under_flag_reg <= 1'b0;
      end else if (conv_done) begin
         result_reg <= data_next;
         over_flag_reg <= over_next;
         under_flag_reg <= under_sync_reg[1];
      end
   end

   // irq flags: a set in the clearing cycle wins
   always_comb begin
      raw_set = 3'h0;
      raw_set[ccc_pkg::IRQ_DONE] = conv_done;
      raw_set[ccc_pkg::IRQ_LOW] = conv_done && (data_next < loth_reg);
      raw_set[ccc_pkg::IRQ_HIGH] = conv_done && (data_next > hith_reg);
      raw_clr = 3'h0;
      if (rd_acc && paddr == ccc_pkg::OFS_RESULT) begin
         raw_clr = 3'h7;
      end else if (wr_acc && paddr == ccc_pkg::OFS_CLEAR) begin
         raw_clr = pwdata[2:0];
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         raw_reg <= 3'h0;
      end else begin
         raw_reg <= (raw_reg & ~raw_clr) | raw_set;
      end
   end

   assign irq = |(raw_reg & mask_reg);

   // front end controls from flops
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         afe_integrate <= 1'b0;
         afe_gain_low <= 1'b1;
         afe_offset_on <= 1'b0;
         afe_offset_pick_a <= 1'b0;
         afe_offset_pick_b <= 1'b0;
         afe_input_select <= 6'h00;
         afe_input_gain <= ccc_pkg::GAIN_RESET;
      end else begin
         afe_integrate <= (state_reg == ccc_pkg::CCC_INTEG);
         afe_gain_low <= setup_reg[ccc_pkg::SET_GAIN_LOW];
         afe_offset_on <= setup_reg[ccc_pkg::SET_OFS_ON];
         afe_offset_pick_a <= setup_reg[ccc_pkg::SET_OFS_A];
         afe_offset_pick_b <= setup_reg[ccc_pkg::SET_OFS_B];
         afe_input_select <= insel_reg;
         afe_input_gain <= gain_reg;
      end
   end
endmodule
`default_nettype wire

// file: tb/ccc_afe_model.sv
// Purpose: front end stand-in, pulse train while integrating
// Assumes: bench sets the pulse period, 0 keeps the line quiet
// Notes: range levels pass straight through from the bench
`timescale 1ns/1ps
`default_nettype none
module ccc_afe_model (
   input wire logic mclk,
   input wire logic afe_integrate,
   input wire logic [7:0] pulse_period,
   input wire logic over_in,
   input wire logic under_in,
   output logic afe_freq_pulse,
   output logic afe_over_range,
   output logic afe_under_range
);
   logic [7:0] ph_reg = 8'h00;
   // phase restarts each time integration starts so counts stay repeatable
   always @(posedge mclk) begin
      if (afe_integrate && ph_reg + 8'h01 < pulse_period)
         ph_reg <= ph_reg + 8'h01;
      else
         ph_reg <= 8'h00;
   end
   // line stands low outside integration
   assign afe_freq_pulse = afe_integrate && pulse_period != 8'h00 &&
      ph_reg < (pulse_period >> 1);
   assign afe_over_range = over_in;
   assign afe_under_range = under_in;
endmodule
`default_nettype wire

// file: tb/ccc_converter_asserts.sv
// Purpose: port checks of the converter control block
// Assumes: zero wait apb, copies of setup bits two edges late at most
// Notes: bound to every converter instance
`timescale 1ns/1ps
`default_nettype none
module ccc_converter_asserts (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic afe_integrate,
   input wire logic afe_gain_low,
   input wire logic afe_offset_on,
   input wire logic irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   sequence apb_rd(logic [11:0] a);
      psel && penable && !pwrite && paddr == a;
   endsequence
   sequence apb_wr(logic [11:0] a);
      psel && penable && pwrite && paddr == a;
   endsequence
   map_refuse_a: assert property (psel && penable &&
      paddr > ccc_pkg::OFS_CLEAR |-> pslverr && pready &&
      (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   map_accept_a: assert property (psel && penable &&
      paddr <= ccc_pkg::OFS_CLEAR && paddr[1:0] == 2'h0 |-> !pslverr && pready)
      else $error("mapped access refused");
   status_bits_a: assert property (apb_rd(ccc_pkg::OFS_STATUS) |->
      prdata[31:2] == 30'h0) else $error("status reserved bits set");
   result_bits_a: assert property (apb_rd(ccc_pkg::OFS_RESULT) |->
      prdata[31:17] == 15'h0) else $error("result reserved bits set");
   setup_copy_a: assert property (apb_wr(ccc_pkg::OFS_SETUP) |->
      ##2 afe_gain_low == $past(pwdata[6], 2) &&
      afe_offset_on == $past(pwdata[8], 2))
      else $error("setup not passed to front end");
   start_conv_a: assert property (apb_wr(ccc_pkg::OFS_CONTROL) ##0
      (pwdata[0] && !afe_integrate) |-> ##[1:2] afe_integrate)
      else $error("start did not begin integration");
   read_clear_a: assert property (apb_rd(ccc_pkg::OFS_RESULT) ##0
      !afe_integrate |=> !irq) else $error("result read left irq set");
   setup_read_a: assert property (apb_rd(ccc_pkg::OFS_SETUP) |->
      (prdata & ~32'h747) == 32'h0) else $error("setup reserved bits set");
   control_bits_a: assert property (apb_rd(ccc_pkg::OFS_CONTROL) |->
      prdata[31:3] == 29'h0 && !prdata[1]) else $error("control bits wrong");
endmodule
bind ccc_converter ccc_converter_asserts u_chk (.mclk(mclk), .reset_n(reset_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .afe_integrate(afe_integrate), .afe_gain_low(afe_gain_low),
   .afe_offset_on(afe_offset_on), .irq(irq));
`default_nettype wire

// file: tb/ccc_converter_tb.sv
// Purpose: register-level bench of the converter control block
// Assumes: zero wait apb, front end model on the analog side
// Notes: custom windows use divider 999, fixed codes divider 2
`timescale 1ns/1ps
`default_nettype none
module ccc_converter_tb;
   logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic afe_pulse, afe_over, afe_under, afe_integrate, over_in, under_in;
   logic gain_low, ofs_on, ofs_a, ofs_b;
   logic [5:0] insel;
   logic [3:0] igain;
   logic [7:0] period;
   int num_errors = 0, n_compared = 0, cyc = 0, t0, t1;
   int win_ms [8] = '{16, 16, 20, 100, 200, 400, 16, 2};
   logic [31:0] rst_val [13] = '{32'h0, 32'h0, 32'h0, 32'h43, 32'h0, 32'h9,
      32'h0, 32'h0, 32'h0, 32'hffff, 32'h0, 32'h0, 32'h0};
   ccc_converter dut (.mclk(mclk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .afe_freq_pulse(afe_pulse), .afe_over_range(afe_over),
      .afe_under_range(afe_under), .afe_integrate(afe_integrate),
      .afe_gain_low(gain_low), .afe_offset_on(ofs_on),
      .afe_offset_pick_a(ofs_a), .afe_offset_pick_b(ofs_b),
      .afe_input_select(insel), .afe_input_gain(igain), .irq(irq));
   ccc_afe_model afe (.mclk(mclk), .afe_integrate(afe_integrate),
      .pulse_period(period), .over_in(over_in), .under_in(under_in),
      .afe_freq_pulse(afe_pulse), .afe_over_range(afe_over),
      .afe_under_range(afe_under));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) cyc <= cyc + 1;
   task automatic give_verdict();
      $display("Checks %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, got);
      n_compared++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask
   // entered just after an edge, leaves one edge after release
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         num_errors++;
         give_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e,
      input string s);
      xfer(1'b0, a, 32'h0);
      chk(s, e, rd);
   endtask
   task automatic wait_int(input logic v, output int t);
      int n;
      n = 0;
      while (afe_integrate !== v && n < 5000) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 5000) begin
         num_errors++;
         give_verdict();
      end
      t = cyc;
   endtask
   initial begin
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      over_in = 1'b0;
      under_in = 1'b0;
      period = 8'h00;
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      for (int i = 0; i < 13; i++)
         rdc(12'(i * 4), rst_val[i], "reset value");
      rdc(12'h038, 32'h0, "unmapped");
      chk("slverr", 32'h1, {31'h0, err});
      wr(ccc_pkg::OFS_SETUP, 32'hffffffff);
      rdc(ccc_pkg::OFS_SETUP, 32'h747, "setup");
      chk("afe setup", 32'hf, {28'h0, gain_low, ofs_on, ofs_a, ofs_b});
      wr(ccc_pkg::OFS_SETUP, 32'h0);
      // front end copies land one edge after the register
      @(posedge mclk);
      chk("afe setup", 32'h0, {28'h0, gain_low, ofs_on, ofs_a, ofs_b});
      wr(ccc_pkg::OFS_GAIN, 32'h9);
      wr(ccc_pkg::OFS_INSEL, 32'h2a);
      rdc(ccc_pkg::OFS_GAIN, 32'h9, "gain");
      rdc(ccc_pkg::OFS_INSEL, 32'h2a, "insel");
      chk("afe route", 32'h2a9, {22'h0, insel, igain});
      wr(ccc_pkg::OFS_CUSTOM, 32'h2);
      for (int c = 0; c < 8; c++) begin
         wr(ccc_pkg::OFS_MSDIV, c == 7 ? 32'd999 : 32'd2);
         wr(ccc_pkg::OFS_SETUP, 32'h40 | 32'(c));
         wr(ccc_pkg::OFS_CONTROL, 32'h1);
         wait_int(1'b1, t0);
         wait_int(1'b0, t1);
         chk("window", win_ms[c] * (c == 7 ? 999 : 2), t1 - t0);
         rdc(ccc_pkg::OFS_CONTROL, 32'h0, "start");
         rdc(ccc_pkg::OFS_RAW, 32'h1, "raw");
         rdc(ccc_pkg::OFS_RESULT, 32'h0, "result");
         rdc(ccc_pkg::OFS_RAW, 32'h0, "raw");
      end
      // about 249 pulses in a 999 cycle window
      wr(ccc_pkg::OFS_CUSTOM, 32'h1);
      wr(ccc_pkg::OFS_LOTH, 32'd1000);
      wr(ccc_pkg::OFS_HITH, 32'd100);
      wr(ccc_pkg::OFS_MASK, 32'h7);
      period <= 8'd4;
      over_in <= 1'b1;
      wr(ccc_pkg::OFS_CONTROL, 32'h1);
      wait_int(1'b1, t0);
      wait_int(1'b0, t1);
      rdc(ccc_pkg::OFS_STATUS, 32'h1, "status");
      rdc(ccc_pkg::OFS_RAW, 32'h7, "raw");
      rdc(ccc_pkg::OFS_MASKED, 32'h7, "masked");
      wr(ccc_pkg::OFS_MASK, 32'h2);
      rdc(ccc_pkg::OFS_MASKED, 32'h2, "masked");
      chk("irq", 32'h1, {31'h0, irq});
      wr(ccc_pkg::OFS_CLEAR, 32'h2);
      rdc(ccc_pkg::OFS_RAW, 32'h5, "raw");
      chk("irq", 32'h0, {31'h0, irq});
      xfer(1'b0, ccc_pkg::OFS_RESULT, 32'h0);
      chk("data", 32'h1, 32'(rd[16] && rd[15:0] > 200 &&
         rd[15:0] < 260));
      rdc(ccc_pkg::OFS_RAW, 32'h0, "raw");
      over_in <= 1'b0;
      under_in <= 1'b1;
      period <= 8'd0;
      wr(ccc_pkg::OFS_CONTROL, 32'h1);
      wait_int(1'b1, t0);
      wait_int(1'b0, t1);
      rdc(ccc_pkg::OFS_STATUS, 32'h2, "status");
      rdc(ccc_pkg::OFS_RAW, 32'h3, "raw");
      rdc(ccc_pkg::OFS_RESULT, 32'h0, "result");
      under_in <= 1'b0;
      wr(ccc_pkg::OFS_CONTROL, 32'h5);
      wait_int(1'b1, t0);
      repeat (1500) @(posedge mclk);
      chk("running", 32'h1, {31'h0, afe_integrate});
      rdc(ccc_pkg::OFS_CONTROL, 32'h5, "control");
      wr(ccc_pkg::OFS_CONTROL, 32'h6);
      wait_int(1'b0, t1);
      chk("stop edge", 32'h0, (t1 - t0) % 999);
      repeat (20) @(posedge mclk);
      chk("halted", 32'h0, {31'h0, afe_integrate});
      rdc(ccc_pkg::OFS_CONTROL, 32'h4, "control");
      wr(ccc_pkg::OFS_CONTROL, 32'h1);
      wait_int(1'b1, t0);
      wr(ccc_pkg::OFS_CONTROL, 32'h2);
      wait_int(1'b0, t1);
      chk("single", 32'd999, t1 - t0);
      give_verdict();
   end
endmodule
`default_nettype wire
